/* File: hdl/xfer_exec_defs.vh */
`ifndef XFER_EXEC_DEFS_VH
`define XFER_EXEC_DEFS_VH

// =====================================================
// operation codes on the decoded-op port
`define OP_NONE 5'h00
`define OP_TABLE_LOOKUP 5'h01
`define OP_MEM_TO_ACC 5'h02
`define OP_Y_TO_ACC 5'h03
`define OP_ACC_TO_B 5'h04
`define OP_LOAD_EXT 5'h05
`define OP_LOAD_BOOL_SEL 5'h06
`define OP_LOAD_PD_LOW 5'h07
`define OP_LOAD_PD_HIGH 5'h08
`define OP_LOAD_T1_CTRL 5'h09
`define OP_LOAD_T2_CTRL 5'h0a
`define OP_SET_BIT8_EN 5'h0b
`define OP_WDOG_SERVICE 5'h0c
`define OP_SWAP 5'h0d
`define OP_SWAP_DEC 5'h0e
`define OP_SWAP_INC 5'h0f
`define OP_WDOG_EVENT 5'h10

// =====================================================
// field positions and constants
`define ROM_BIT8 8
`define ROM_HI_MSB 7
`define ROM_HI_LSB 4
`define ROM_LO_MSB 3
`define ROM_LO_LSB 0
`define Y_WRAP_DEC 4'hf
`define Y_WRAP_INC 4'h0
`define NIB_ZERO 4'h0
`define NIB_ONE 4'h1
`define EXT_ZERO 8'h00
`define SP_ZERO 2'h0
`define SP_ONE 2'h1
`define PC_ZERO 11'h000
`define X_ZERO 2'h0
`define SEL_ZERO 2'h0
`define T1_ZERO 3'h0
`define J_MSB 1
`define J_LSB 0
`define SEL_MSB 1
`define SEL_LSB 0
`define T1_MSB 2
`define T1_LSB 0
`define SP_WIDTH 2

`endif

/* File: hdl/xfer_stack.v */
`timescale 1ns/10ps
`include "xfer_exec_defs.vh"

// =====================================================
// return stack, flip-flop storage indexed by pointer
module xfer_stack #(
    parameter DEPTH = 4,
    parameter PCW = 11,
    parameter SPW = 2
) (
    input wire clk, // clock
    input wire rst_n, // sync reset
    input wire push, // push pc
    input wire pop, // pop to top
    input wire [PCW-1:0] push_val, // value pushed
    output wire [PCW-1:0] top_val // entry below pointer
);
    reg [PCW-1:0] mem_r [0:DEPTH-1];
    reg [SPW-1:0] sp_r;
    wire [SPW-1:0] sp_dec = sp_r - `SP_ONE;
    assign top_val = mem_r[sp_dec];

    always @(posedge clk) begin
        if (!rst_n) begin
            sp_r <= `SP_ZERO;
        end else if (push) begin
            sp_r <= sp_r + `SP_ONE;
        end else if (pop) begin
            sp_r <= sp_dec;
        end
    end

    genvar i;
    generate
        for (i = 0; i < DEPTH; i = i + 1) begin : g_ent
            always @(posedge clk) begin
                if (!rst_n) begin
                    mem_r[i] <= {PCW{1'h0}};
                end else if (push && sp_r == i) begin
                    mem_r[i] <= push_val;
                end
            end
        end
    endgenerate
endmodule // xfer_stack

/* File: hdl/xfer_exec.v */
`timescale 1ns/10ps
`include "xfer_exec_defs.vh"

// =====================================================
// transfer-group execute unit
module xfer_exec #(
    parameter PCW = 11,
    parameter ROMW = 9,
    parameter PAGEW = 4,
    parameter DEPTH = 4
) (
    input wire CLK, // system clock
    input wire RST_N, // sync reset, low active
    input wire OP_VALID, // one-cycle op strobe
    input wire [4:0] OP_CODE, // decoded operation
    input wire [3:0] OPERAND, // page or j in low bits
    input wire [PCW-1:0] PC_IN, // current pc
    input wire [2:0] TABLE_HIGH_ADDRESS_REG, // d register value
    input wire [3:0] MEM_RDATA, // addressed ram nibble
    input wire [ROMW-1:0] ROM_RDATA, // rom word for ROM_ADDR, same cycle
    output reg [PCW-1:0] ROM_ADDR, // lookup address
    output reg ROM_REQ, // lookup fetch cycle
    output reg [PCW-1:0] PC_RESUME, // popped pc
    output reg PC_LOAD, // pulse: load PC_RESUME
    output reg BUSY, // lookup in progress
    output reg [3:0] MEM_WDATA, // ram write data
    output reg MEM_WE, // ram write pulse
    output reg SKIP, // pulse: skip next instruction
    output reg [3:0] ACC, // accumulator
    output reg [3:0] B_REG, // register b
    output reg [1:0] X_REG, // register x
    output reg [3:0] Y_REG, // register y
    output reg CARRY, // carry flag
    output reg [7:0] EXTENDED_REG, // register e
    output reg [1:0] BOOL_FUNCTION_SELECT, // logic select
    output reg [3:0] PULLDOWN_ENABLE_LOW, // pull-down low
    output reg [3:0] PULLDOWN_ENABLE_HIGH, // pull-down high
    output reg [2:0] TIMER_ONE_CONTROL, // timer one control
    output reg [3:0] TIMER_TWO_CONTROL, // timer two control
    output reg ROM_BIT8_ENABLE_FLAG, // upper rom bit flag
    output reg WATCHDOG_FLAG_ONE // watchdog flag one
);
    // =====================================================
    // lookup sequencer states, one-hot
    localparam S_IDLE = 3'h1;
    localparam S_FETCH = 3'h2;
    localparam S_POP = 3'h4;

    reg [2:0] state_r;
    reg [2:0] state_nxt;
    wire [PCW-1:0] top_val;
    wire in_fetch = (state_r == S_FETCH);
    wire in_pop = (state_r == S_POP);
    // an op is refused while a lookup still owns the datapath
    wire go = OP_VALID && state_r == S_IDLE;

    // =====================================================
    // one decode line per accepted operation
    wire do_lookup = go && OP_CODE == `OP_TABLE_LOOKUP;
    wire do_mem_to_acc = go && OP_CODE == `OP_MEM_TO_ACC;
    wire do_y_to_acc = go && OP_CODE == `OP_Y_TO_ACC;
    wire do_acc_to_b = go && OP_CODE == `OP_ACC_TO_B;
    wire do_load_ext = go && OP_CODE == `OP_LOAD_EXT;
    wire do_bool_sel = go && OP_CODE == `OP_LOAD_BOOL_SEL;
    wire do_pd_low = go && OP_CODE == `OP_LOAD_PD_LOW;
    wire do_pd_high = go && OP_CODE == `OP_LOAD_PD_HIGH;
    wire do_t1_ctrl = go && OP_CODE == `OP_LOAD_T1_CTRL;
    wire do_t2_ctrl = go && OP_CODE == `OP_LOAD_T2_CTRL;
    wire do_set_bit8 = go && OP_CODE == `OP_SET_BIT8_EN;
    wire do_wdog_service = go && OP_CODE == `OP_WDOG_SERVICE;
    wire do_wdog_event = go && OP_CODE == `OP_WDOG_EVENT;
    wire do_swap_plain = go && OP_CODE == `OP_SWAP;
    wire do_swap_dec = go && OP_CODE == `OP_SWAP_DEC;
    wire do_swap_inc = go && OP_CODE == `OP_SWAP_INC;
    wire do_swap = do_swap_plain || do_swap_dec || do_swap_inc;
    wire do_x_update = do_mem_to_acc || do_swap;

    // =====================================================
    // datapath helpers
    wire [3:0] y_dec = Y_REG - `NIB_ONE;
    wire [3:0] y_inc = Y_REG + `NIB_ONE;
    wire [1:0] op_j = OPERAND[`J_MSB:`J_LSB];
    wire [PCW-1:0] look_addr = {OPERAND[PAGEW-1:0], TABLE_HIGH_ADDRESS_REG, ACC};

    // =====================================================
    // return stack: push in lookup cycle 0, pop in cycle 2
    xfer_stack #(.DEPTH(DEPTH), .PCW(PCW), .SPW(`SP_WIDTH)) u_stack (
        .clk(CLK),
        .rst_n(RST_N),
        .push(do_lookup),
        .pop(in_pop),
        .push_val(PC_IN),
        .top_val(top_val)
    );

    // =====================================================
    // lookup sequencer
    always @* begin
        case (state_r)
            S_IDLE: state_nxt = do_lookup ? S_FETCH : S_IDLE;
            S_FETCH: state_nxt = S_POP;
            S_POP: state_nxt = S_IDLE;
            default: state_nxt = S_IDLE;
        endcase
    end

    always @(posedge CLK) begin
        if (!RST_N) begin
            state_r <= S_IDLE;
            ROM_REQ <= 1'h0;
            BUSY <= 1'h0;
        end else begin
            state_r <= state_nxt;
            ROM_REQ <= do_lookup;
            BUSY <= do_lookup || in_fetch;
        end
    end

    always @(posedge CLK) begin
        if (!RST_N) begin
            ROM_ADDR <= `PC_ZERO;
        end else if (do_lookup) begin
            ROM_ADDR <= look_addr;
        end
    end

    // the popped pc is handed out with a one-cycle load pulse
    always @(posedge CLK) begin
        if (!RST_N) begin
            PC_RESUME <= `PC_ZERO;
            PC_LOAD <= 1'h0;
        end else begin
            PC_LOAD <= in_pop;
            if (in_pop) begin
                PC_RESUME <= top_val;
            end
        end
    end

    // =====================================================
    // accumulator, B and carry
    // rom data is combinational, so it is taken in the fetch cycle while ROM_REQ is high
    always @(posedge CLK) begin
        if (!RST_N) begin
            ACC <= `NIB_ZERO;
        end else if (in_fetch) begin
            ACC <= ROM_RDATA[`ROM_LO_MSB:`ROM_LO_LSB];
        end else if (do_mem_to_acc || do_swap) begin
            ACC <= MEM_RDATA;
        end else if (do_y_to_acc) begin
            ACC <= Y_REG;
        end
    end

    always @(posedge CLK) begin
        if (!RST_N) begin
            B_REG <= `NIB_ZERO;
        end else if (in_fetch) begin
            B_REG <= ROM_RDATA[`ROM_HI_MSB:`ROM_HI_LSB];
        end else if (do_acc_to_b) begin
            B_REG <= ACC;
        end
    end

    // carry moves only on a lookup with the bit-8 flag set; plain transfers leave it alone
    always @(posedge CLK) begin
        if (!RST_N) begin
            CARRY <= 1'h0;
        end else if (in_fetch && ROM_BIT8_ENABLE_FLAG) begin
            CARRY <= ROM_RDATA[`ROM_BIT8];
        end
    end

    // =====================================================
    // ram pointer registers and skip
    always @(posedge CLK) begin
        if (!RST_N) begin
            X_REG <= `X_ZERO;
        end else if (do_x_update) begin
            X_REG <= X_REG ^ op_j;
        end
    end

    always @(posedge CLK) begin
        if (!RST_N) begin
            Y_REG <= `NIB_ZERO;
            SKIP <= 1'h0;
        end else begin
            SKIP <= 1'h0;
            if (do_swap_dec) begin
                Y_REG <= y_dec;
                SKIP <= (y_dec == `Y_WRAP_DEC);
            end else if (do_swap_inc) begin
                Y_REG <= y_inc;
                SKIP <= (y_inc == `Y_WRAP_INC);
            end
        end
    end

    // the old accumulator goes back to ram in the cycle after the nibble comes in, with MEM_WE registered
    always @(posedge CLK) begin
        if (!RST_N) begin
            MEM_WDATA <= `NIB_ZERO;
            MEM_WE <= 1'h0;
        end else begin
            MEM_WE <= do_swap;
            if (do_swap) begin
                MEM_WDATA <= ACC;
            end
        end
    end

    // =====================================================
    // control registers loaded from the accumulator; E takes B and the accumulator
    always @(posedge CLK) begin
        if (!RST_N) begin
            EXTENDED_REG <= `EXT_ZERO;
        end else if (do_load_ext) begin
            EXTENDED_REG <= {B_REG, ACC};
        end
    end

    always @(posedge CLK) begin
        if (!RST_N) begin
            BOOL_FUNCTION_SELECT <= `SEL_ZERO;
        end else if (do_bool_sel) begin
            BOOL_FUNCTION_SELECT <= ACC[`SEL_MSB:`SEL_LSB];
        end
    end

    always @(posedge CLK) begin
        if (!RST_N) begin
            PULLDOWN_ENABLE_LOW <= `NIB_ZERO;
        end else if (do_pd_low) begin
            PULLDOWN_ENABLE_LOW <= ACC;
        end
    end

    always @(posedge CLK) begin
        if (!RST_N) begin
            PULLDOWN_ENABLE_HIGH <= `NIB_ZERO;
        end else if (do_pd_high) begin
            PULLDOWN_ENABLE_HIGH <= ACC;
        end
    end

    always @(posedge CLK) begin
        if (!RST_N) begin
            TIMER_ONE_CONTROL <= `T1_ZERO;
        end else if (do_t1_ctrl) begin
            TIMER_ONE_CONTROL <= ACC[`T1_MSB:`T1_LSB];
        end
    end

    always @(posedge CLK) begin
        if (!RST_N) begin
            TIMER_TWO_CONTROL <= `NIB_ZERO;
        end else if (do_t2_ctrl) begin
            TIMER_TWO_CONTROL <= ACC;
        end
    end

    // =====================================================
    // status flags
    // the bit-8 flag is sticky: only reset clears it
    always @(posedge CLK) begin
        if (!RST_N) begin
            ROM_BIT8_ENABLE_FLAG <= 1'h0;
        end else if (do_set_bit8) begin
            ROM_BIT8_ENABLE_FLAG <= 1'h1;
        end
    end

    // one op arrives per cycle, so set and service cannot meet; the set is ranked first anyway
    always @(posedge CLK) begin
        if (!RST_N) begin
            WATCHDOG_FLAG_ONE <= 1'h0;
        end else if (do_wdog_event) begin
            WATCHDOG_FLAG_ONE <= 1'h1;
        end else if (do_wdog_service) begin
            WATCHDOG_FLAG_ONE <= 1'h0;
        end
    end
endmodule // xfer_exec

/* File: tb/xfer_exec_monitor.sv */
`timescale 1ns/10ps
`include "xfer_exec_defs.vh"
// ==========
// port checks
module xfer_exec_monitor (
    input wire CLK, // clock
    input wire RST_N, // reset
    input wire OP_VALID, // strobe
    input wire [4:0] OP_CODE, // op
    input wire [3:0] OPERAND, // page or j
    input wire [10:0] PC_IN, // pc
    input wire [2:0] TABLE_HIGH_ADDRESS_REG, // d
    input wire [3:0] MEM_RDATA, // ram
    input wire [8:0] ROM_RDATA, // rom
    input wire [10:0] ROM_ADDR, // rom addr
    input wire ROM_REQ, // fetch
    input wire [10:0] PC_RESUME, // resume pc
    input wire PC_LOAD, // pc load
    input wire BUSY, // busy
    input wire [3:0] MEM_WDATA, // ram data
    input wire MEM_WE, // ram we
    input wire SKIP, // skip
    input wire [3:0] ACC, // a
    input wire [3:0] B_REG, // b
    input wire [1:0] X_REG, // x
    input wire [3:0] Y_REG, // y
    input wire CARRY, // cy
    input wire ROM_BIT8_ENABLE_FLAG // bit8
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);
    wire take = OP_VALID && !BUSY;
    sequence s_fetch;
        ROM_REQ && BUSY && ROM_ADDR == {$past(OPERAND), $past(TABLE_HIGH_ADDRESS_REG), $past(ACC)};
    endsequence
    sequence s_resume;
        !BUSY && PC_LOAD && PC_RESUME == $past(PC_IN, 3);
    endsequence
    a_lookup_flow: assert property (take && OP_CODE == `OP_TABLE_LOOKUP |=>
        s_fetch ##1 (BUSY && !ROM_REQ) ##1 s_resume) else $error("lookup flow wrong");
    a_lookup_data: assert property (take && OP_CODE == `OP_TABLE_LOOKUP ##1 1'b1 |=>
        B_REG == $past(ROM_RDATA[7:4]) && ACC == $past(ROM_RDATA[3:0]) &&
        CARRY == (ROM_BIT8_ENABLE_FLAG ? $past(ROM_RDATA[8]) : $past(CARRY)))
        else $error("lookup data wrong");
    a_mem_acc: assert property (take && OP_CODE == `OP_MEM_TO_ACC |=>
        ACC == $past(MEM_RDATA) && X_REG == ($past(X_REG) ^ $past(OPERAND[1:0])))
        else $error("mem to acc wrong");
    a_y_acc: assert property (take && OP_CODE == `OP_Y_TO_ACC |=>
        ACC == $past(Y_REG) && $stable(CARRY)) else $error("y to acc wrong");
    a_acc_b: assert property (take && OP_CODE == `OP_ACC_TO_B |=>
        B_REG == $past(ACC) && $stable(CARRY)) else $error("acc to b wrong");
    a_swap_plain: assert property (take && OP_CODE == `OP_SWAP |=>
        MEM_WE && MEM_WDATA == $past(ACC) && ACC == $past(MEM_RDATA) &&
        X_REG == ($past(X_REG) ^ $past(OPERAND[1:0]))) else $error("swap wrong");
    a_swap_dec: assert property (take && OP_CODE == `OP_SWAP_DEC |=>
        MEM_WE && MEM_WDATA == $past(ACC) && Y_REG == $past(Y_REG) - 4'h1 &&
        SKIP == (Y_REG == 4'hf)) else $error("swap dec wrong");
    a_swap_inc: assert property (take && OP_CODE == `OP_SWAP_INC |=>
        MEM_WE && MEM_WDATA == $past(ACC) && Y_REG == $past(Y_REG) + 4'h1 &&
        SKIP == (Y_REG == 4'h0)) else $error("swap inc wrong");
endmodule // xfer_exec_monitor

/* File: tb/tb_top.sv */
`timescale 1ns/10ps
`include "xfer_exec_defs.vh"
// ==========
// random ops against a shadow model
module tb_top;
    reg CLK, RST_N, OP_VALID;
    reg [4:0] OP_CODE;
    reg [3:0] OPERAND, MEM_RDATA, m_acc, m_b, m_y;
    reg [2:0] TABLE_HIGH_ADDRESS_REG;
    reg [10:0] PC_IN;
    reg [1:0] m_x;
    reg m_cy, m_bit8;
    reg [8:0] w;
    reg [31:0] r;
    integer failures, checks;
    wire [10:0] ROM_ADDR, PC_RESUME;
    wire [3:0] MEM_WDATA, ACC, B_REG, Y_REG, PULLDOWN_ENABLE_LOW, PULLDOWN_ENABLE_HIGH;
    wire [3:0] TIMER_TWO_CONTROL;
    wire [2:0] TIMER_ONE_CONTROL;
    wire [1:0] X_REG, BOOL_FUNCTION_SELECT;
    wire [7:0] EXTENDED_REG;
    wire ROM_REQ, PC_LOAD, BUSY, MEM_WE, SKIP, CARRY, ROM_BIT8_ENABLE_FLAG, WATCHDOG_FLAG_ONE;
    function [8:0] rom_f(input [10:0] a);
        rom_f = {^a, a[7:0] ^ 8'ha5};
    endfunction
    wire [8:0] ROM_RDATA = rom_f(ROM_ADDR);
    xfer_exec uut (.CLK, .RST_N, .OP_VALID, .OP_CODE, .OPERAND, .PC_IN, .TABLE_HIGH_ADDRESS_REG,
        .MEM_RDATA, .ROM_RDATA, .ROM_ADDR, .ROM_REQ, .PC_RESUME, .PC_LOAD, .BUSY, .MEM_WDATA,
        .MEM_WE, .SKIP, .ACC, .B_REG, .X_REG, .Y_REG, .CARRY, .EXTENDED_REG,
        .BOOL_FUNCTION_SELECT, .PULLDOWN_ENABLE_LOW, .PULLDOWN_ENABLE_HIGH,
        .TIMER_ONE_CONTROL, .TIMER_TWO_CONTROL, .ROM_BIT8_ENABLE_FLAG, .WATCHDOG_FLAG_ONE);
    task chk(input [10:0] seen, input [10:0] exp);
        begin
            checks = checks + 1;
            if (seen !== exp) begin
                failures = failures + 1;
                $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task finish_test;
        begin
            $display("checks %0d failures %0d", checks, failures);
            if (failures == 0 && checks > 0) $display("bench passed");
            else $display("bench failed");
            $finish;
        end
    endtask
    task op(input [4:0] code);
        reg [31:0] s;
        begin
            s = $urandom;
            @(posedge CLK);
            OP_VALID <= 1'h1;
            OP_CODE <= code;
            {TABLE_HIGH_ADDRESS_REG, PC_IN, MEM_RDATA, OPERAND} <= s[21:0];
            @(posedge CLK);
            // a busy lookup must drop this second request
            OP_VALID <= (code == `OP_TABLE_LOOKUP);
            OP_CODE <= `OP_ACC_TO_B;
            #1;
            case (code)
                `OP_Y_TO_ACC: m_acc = m_y;
                `OP_ACC_TO_B: m_b = m_acc;
                `OP_LOAD_EXT: chk(EXTENDED_REG, {m_b, m_acc});
                `OP_LOAD_BOOL_SEL: chk(BOOL_FUNCTION_SELECT, m_acc[1:0]);
                `OP_LOAD_PD_LOW: chk(PULLDOWN_ENABLE_LOW, m_acc);
                `OP_LOAD_PD_HIGH: chk(PULLDOWN_ENABLE_HIGH, m_acc);
                `OP_LOAD_T1_CTRL: chk(TIMER_ONE_CONTROL, m_acc[2:0]);
                `OP_LOAD_T2_CTRL: chk(TIMER_TWO_CONTROL, m_acc);
                `OP_SET_BIT8_EN: m_bit8 = 1'h1;
                `OP_WDOG_SERVICE: chk(WATCHDOG_FLAG_ONE, 1'h0);
                `OP_WDOG_EVENT: chk(WATCHDOG_FLAG_ONE, 1'h1);
                `OP_SWAP, `OP_SWAP_DEC, `OP_SWAP_INC: begin
                    chk(MEM_WDATA, m_acc);
                    chk(MEM_WE, 1'h1);
                    m_y = m_y + (code == `OP_SWAP_INC) - (code == `OP_SWAP_DEC);
                    chk(SKIP, code != `OP_SWAP && m_y == {4{code == `OP_SWAP_DEC}});
                end
                `OP_TABLE_LOOKUP: begin
                    w = rom_f({OPERAND, TABLE_HIGH_ADDRESS_REG, m_acc});
                    chk(ROM_ADDR, {OPERAND, TABLE_HIGH_ADDRESS_REG, m_acc});
                    @(posedge CLK);
                    OP_VALID <= 1'h0;
                    #1;
                    chk(BUSY, 1'h1);
                    {m_b, m_acc} = w[7:0];
                    if (m_bit8) m_cy = w[8];
                    @(posedge CLK);
                    #1;
                    chk(PC_LOAD, 1'h1);
                    chk(PC_RESUME, PC_IN);
                end
                default: ;
            endcase
            if (code == `OP_MEM_TO_ACC || (code >= `OP_SWAP && code <= `OP_SWAP_INC)) begin
                m_acc = MEM_RDATA;
                m_x = m_x ^ OPERAND[1:0];
            end
            chk(ACC, m_acc);
            chk(B_REG, m_b);
            chk(X_REG, m_x);
            chk(Y_REG, m_y);
            chk(CARRY, m_cy);
            chk(ROM_BIT8_ENABLE_FLAG, m_bit8);
            chk(MEM_WE, code >= `OP_SWAP && code <= `OP_SWAP_INC);
            chk(BUSY, 1'h0);
            if (code != `OP_SWAP_DEC && code != `OP_SWAP_INC) chk(SKIP, 1'h0);
        end
    endtask
    initial begin
        CLK = 1'h0;
        forever #5 CLK = ~CLK;
    end
    initial begin
        #100000;
        failures = failures + 1;
        finish_test;
    end
    initial begin
        r = $urandom(69);
        failures = 0;
        checks = 0;
        {OP_VALID, OP_CODE, OPERAND, MEM_RDATA, PC_IN, TABLE_HIGH_ADDRESS_REG} = 28'h000_0000;
        {m_acc, m_b, m_x, m_y, m_cy, m_bit8} = 16'h0000;
        RST_N = 1'h0;
        repeat (2) @(posedge CLK);
        RST_N <= 1'h1;
        op(`OP_SWAP_DEC);
        op(`OP_SWAP_INC);
        op(`OP_WDOG_EVENT);
        op(`OP_WDOG_SERVICE);
        op(`OP_TABLE_LOOKUP);
        op(`OP_SET_BIT8_EN);
        op(`OP_TABLE_LOOKUP);
        repeat (200) begin
            r = $urandom;
            op({1'h0, r[3:0]} + 5'h01);
        end
        finish_test;
    end
endmodule // tb_top
bind xfer_exec xfer_exec_monitor mon (.CLK, .RST_N, .OP_VALID, .OP_CODE, .OPERAND, .PC_IN,
    .TABLE_HIGH_ADDRESS_REG, .MEM_RDATA, .ROM_RDATA, .ROM_ADDR, .ROM_REQ, .PC_RESUME, .PC_LOAD,
    .BUSY, .MEM_WDATA, .MEM_WE, .SKIP, .ACC, .B_REG, .X_REG, .Y_REG, .CARRY,
    .ROM_BIT8_ENABLE_FLAG);
